//--- hdl/ecf_pkg.sv
package ecf_pkg;
    localparam int NUM_PHYS       = 4;
    localparam int PHY_W          = 2;
    localparam int ADDR_W         = 64;
    localparam int RATE_W         = 2;
    localparam int TBL_ENTRIES    = 4;
    localparam int TBL_IDX_W      = 2;
    localparam int RST_SYNC_LEN   = 2;
    localparam logic [ADDR_W-1:0] OWN_ADDR_RST = 64'h0000_0000_0000_0000;

    typedef enum logic [1:0]
    {
        ECF_ROUTE_DIRECT      = 2'h0,
        ECF_ROUTE_SUBTRACTIVE = 2'h1,
        ECF_ROUTE_TABLE       = 2'h2
    } ecf_route_t;

    typedef enum logic [1:0]
    {
        ECF_STAT_AVAIL   = 2'h0,
        ECF_STAT_PARTIAL = 2'h1,
        ECF_STAT_BLOCKED = 2'h2,
        ECF_STAT_CONN    = 2'h3
    } ecf_stat_t;

    typedef enum logic [2:0]
    {
        ECF_CNF_NONE      = 3'h0,
        ECF_CNF_NORMAL    = 3'h1,
        ECF_CNF_WAIT_PART = 3'h2,
        ECF_CNF_BLK_PART  = 3'h3,
        ECF_CNF_WAIT_CONN = 3'h4,
        ECF_CNF_ARB_WON   = 3'h5,
        ECF_CNF_ARB_LOST  = 3'h6,
        ECF_CNF_NO_DEST   = 3'h7
    } ecf_cnf_t;

    typedef enum logic [1:0]
    {
        ECF_ST_IDLE  = 2'h0,
        ECF_ST_ROUTE = 2'h1,
        ECF_ST_DECIDE = 2'h2
    } ecf_state_t;
endpackage

//--- hdl/ecf_bcast_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ecf_bcast_if;
    logic [ecf_pkg::NUM_PHYS-1:0] req;
    logic [ecf_pkg::NUM_PHYS-1:0] port_grp [ecf_pkg::NUM_PHYS];
    logic                         cfg_done;
    logic [ecf_pkg::NUM_PHYS-1:0] tx;
    logic                         tx_change;
    modport mgr (output req, output port_grp, output cfg_done, input tx, input tx_change);
    modport proc (input req, input port_grp, input cfg_done, output tx, output tx_change);
endinterface
`default_nettype wire

//--- hdl/ecf_broadcast_processor.sv
`timescale 1ns/1ps
`default_nettype none
module ecf_broadcast_processor
(
    input  wire logic   mclk,    // device clock
    input  wire logic   rst_n,   // synchronised reset
    ecf_bcast_if.proc   bif      // broadcast requests and transmit requests
);
    localparam int N = ecf_pkg::NUM_PHYS;

    logic [N-1:0] next_tx;
    logic         cfg_q;
    logic [N-1:0] tx;
    logic         tx_change;

    // flood to all phys not sharing the source's port
    always_comb
    begin
        next_tx = '0;
        for (int s = 0; s < N; s++)
            if (bif.req[s])
                next_tx = next_tx | ~bif.port_grp[s];
    end

    assign bif.tx        = tx;
    assign bif.tx_change = tx_change;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx        <= '0;
            tx_change <= 1'b0;
            cfg_q     <= 1'b0;
        end
        else
        begin
            tx        <= next_tx;
            cfg_q     <= bif.cfg_done;
            tx_change <= bif.cfg_done & ~cfg_q;
        end
    end
endmodule
`default_nettype wire

//--- hdl/ecf_fabric.sv
`timescale 1ns/1ps
`default_nettype none
module ecf_fabric
(
    input  wire logic                                   mclk,          // 200 MHz clock
    input  wire logic                                   reset_n,       // async reset, low
    input  wire logic [ecf_pkg::ADDR_W-1:0]             own_addr,      // expander address
    input  wire logic [ecf_pkg::NUM_PHYS*ecf_pkg::ADDR_W-1:0] attached_addr, // per phy
    input  wire logic [ecf_pkg::NUM_PHYS*2-1:0]         route_attr,    // per phy routing type
    input  wire logic [ecf_pkg::NUM_PHYS*ecf_pkg::RATE_W-1:0] phy_rate, // per phy max rate
    input  wire logic [ecf_pkg::NUM_PHYS-1:0]           path_req,      // request path pulse
    input  wire logic [ecf_pkg::NUM_PHYS*ecf_pkg::ADDR_W-1:0] req_dest, // request destination
    input  wire logic [ecf_pkg::NUM_PHYS*ecf_pkg::RATE_W-1:0] req_rate, // request rate
    input  wire logic [ecf_pkg::NUM_PHYS-1:0]           ppt_expired,   // partial timeout
    input  wire logic [ecf_pkg::NUM_PHYS*2-1:0]         phy_status,    // pathway status
    input  wire logic [ecf_pkg::NUM_PHYS-1:0]           conn_close,    // release pairing
    input  wire logic [ecf_pkg::NUM_PHYS-1:0]           bcast_req,     // broadcast from phy
    input  wire logic                                   cfg_done,      // self-config done
    input  wire logic                                   tbl_we,        // table write
    input  wire logic [ecf_pkg::TBL_IDX_W-1:0]          tbl_idx,       // table index
    input  wire logic [ecf_pkg::ADDR_W-1:0]             tbl_addr,      // table address
    input  wire logic [ecf_pkg::PHY_W-1:0]              tbl_phy,       // table phy
    output logic      [ecf_pkg::NUM_PHYS*3-1:0]         cnf,           // confirmation per phy
    output logic      [ecf_pkg::NUM_PHYS*ecf_pkg::PHY_W-1:0] pair_phy, // paired phy per phy
    output logic      [ecf_pkg::NUM_PHYS-1:0]           pair_valid,    // pairing active
    output logic      [ecf_pkg::NUM_PHYS-1:0]           bcast_tx,      // transmit broadcast
    output logic                                        bcast_change,  // transmit change
    output logic      [ecf_pkg::NUM_PHYS-1:0]           port_mismatch  // attribute mismatch
);
    localparam int N = ecf_pkg::NUM_PHYS;
    localparam int AW = ecf_pkg::ADDR_W;
    localparam int PW = ecf_pkg::PHY_W;
    localparam int RW = ecf_pkg::RATE_W;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [ecf_pkg::RST_SYNC_LEN-1:0] rst_sync;
    logic                             rst_n;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync <= '0;
        else
            rst_sync <= {rst_sync[ecf_pkg::RST_SYNC_LEN-2:0], 1'b1};
    end
    assign rst_n = rst_sync[ecf_pkg::RST_SYNC_LEN-1];

    function automatic logic [AW-1:0] addr_of(input logic [N*AW-1:0] v, input int i);
        addr_of = v[i*AW +: AW];
    endfunction

    // ------------------------------------------------------------
    // port grouping
    // ------------------------------------------------------------
    logic [N-1:0] port_grp [N];
    logic [N-1:0] next_mismatch;
    always_comb
    begin
        next_mismatch = '0;
        for (int i = 0; i < N; i++)
        begin
            for (int j = 0; j < N; j++)
            begin
                port_grp[i][j] = (addr_of(attached_addr, i) == addr_of(attached_addr, j));
                if (port_grp[i][j] && route_attr[i*2 +: 2] != route_attr[j*2 +: 2])
                    next_mismatch[i] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // routing table, one address and phy per entry
    // ------------------------------------------------------------
    logic [AW-1:0] tbl_a [ecf_pkg::TBL_ENTRIES];
    logic [PW-1:0] tbl_p [ecf_pkg::TBL_ENTRIES];
    logic [ecf_pkg::TBL_ENTRIES-1:0] tbl_v;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tbl_v <= '0;
        else if (tbl_we)
            tbl_v[tbl_idx] <= 1'b1;
    end
    always_ff @(posedge mclk)
    begin
        if (tbl_we)
        begin
            tbl_a[tbl_idx] <= tbl_addr;
            tbl_p[tbl_idx] <= tbl_phy;
        end
    end

    // ------------------------------------------------------------
    // request select and route lookup
    // ------------------------------------------------------------
    ecf_pkg::ecf_state_t state;
    logic [N-1:0]  pend;
    logic [PW-1:0] src;
    logic [AW-1:0] dst_addr;
    logic [RW-1:0] dst_rate;
    logic [N-1:0]  dest_set;
    logic          sel_any;
    logic [PW-1:0] sel_idx;
    logic [N-1:0]  busy;

    // round robin would be fairer; fixed priority keeps the arbiter small
    always_comb
    begin
        sel_any = 1'b0;
        sel_idx = '0;
        for (int i = N-1; i >= 0; i--)
            if (pend[i])
            begin
                sel_any = 1'b1;
                sel_idx = PW'(i);
            end
    end

    // direct match, then table, then subtractive phys
    always_comb
    begin
        dest_set = '0;
        for (int i = 0; i < N; i++)
            if (addr_of(attached_addr, i) == dst_addr
                && route_attr[i*2 +: 2] == 2'(ecf_pkg::ECF_ROUTE_DIRECT))
                dest_set = port_grp[i];
        if (dest_set == '0)
            for (int t = 0; t < ecf_pkg::TBL_ENTRIES; t++)
                if (tbl_v[t] && tbl_a[t] == dst_addr)
                    dest_set = port_grp[tbl_p[t]];
        if (dest_set == '0)
            for (int i = 0; i < N; i++)
                if (route_attr[i*2 +: 2] == 2'(ecf_pkg::ECF_ROUTE_SUBTRACTIVE))
                    dest_set[i] = 1'b1;
        // own address belongs to the internal management target, never an external phy
        if (dst_addr == own_addr)
            dest_set = '0;
        dest_set[src] = 1'b0;
    end

    // ------------------------------------------------------------
    // destination status summary
    // ------------------------------------------------------------
    logic          rate_ok;
    logic          all_blk;
    logic          all_part;
    logic          all_conn;
    logic          free_any;
    logic [PW-1:0] free_idx;
    always_comb
    begin
        rate_ok  = 1'b0;
        all_blk  = 1'b1;
        all_part = 1'b1;
        all_conn = 1'b1;
        free_any = 1'b0;
        free_idx = '0;
        for (int i = N-1; i >= 0; i--)
            if (dest_set[i])
            begin
                if (phy_rate[i*RW +: RW] >= dst_rate)
                    rate_ok = 1'b1;
                if (phy_status[i*2 +: 2] != 2'(ecf_pkg::ECF_STAT_BLOCKED))
                    all_blk = 1'b0;
                if (phy_status[i*2 +: 2] == 2'(ecf_pkg::ECF_STAT_AVAIL)
                    || phy_status[i*2 +: 2] == 2'(ecf_pkg::ECF_STAT_CONN))
                    all_part = 1'b0;
                if (phy_status[i*2 +: 2] == 2'(ecf_pkg::ECF_STAT_AVAIL))
                    all_conn = 1'b0;
                if (phy_status[i*2 +: 2] == 2'(ecf_pkg::ECF_STAT_AVAIL) && !busy[i]
                    && phy_rate[i*RW +: RW] >= dst_rate)
                begin
                    free_any = 1'b1;
                    free_idx = PW'(i);
                end
            end
    end

    // ------------------------------------------------------------
    // connection manager sequence
    // ------------------------------------------------------------
    logic [2:0]    cnf_r [N];
    logic [PW-1:0] pair_r [N];
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= ecf_pkg::ECF_ST_IDLE;
            pend     <= '0;
            src      <= '0;
            dst_addr <= '0;
            dst_rate <= '0;
            busy     <= '0;
            for (int i = 0; i < N; i++)
            begin
                cnf_r[i]  <= 3'(ecf_pkg::ECF_CNF_NONE);
                pair_r[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (path_req[i])
                begin
                    pend[i]  <= 1'b1;
                    cnf_r[i] <= 3'(ecf_pkg::ECF_CNF_NORMAL);
                end
                if (ppt_expired[i] && pend[i])
                begin
                    pend[i]  <= 1'b0;
                    cnf_r[i] <= 3'(ecf_pkg::ECF_CNF_ARB_LOST);
                end
                if (conn_close[i] && busy[i])
                begin
                    busy[i]         <= 1'b0;
                    busy[pair_r[i]] <= 1'b0;
                end
            end
            case (state)
                ecf_pkg::ECF_ST_IDLE:
                    if (sel_any)
                    begin
                        src      <= sel_idx;
                        dst_addr <= addr_of(req_dest, int'(sel_idx));
                        dst_rate <= req_rate[sel_idx*RW +: RW];
                        state    <= ecf_pkg::ECF_ST_DECIDE;
                    end
                ecf_pkg::ECF_ST_DECIDE:
                begin
                    state <= ecf_pkg::ECF_ST_IDLE;
                    // an abandoned request gets no decision, so the lost code stands
                    if (ppt_expired[src] || !pend[src])
                        pend[src] <= 1'b0;
                    else if (dest_set == '0 || !rate_ok)
                    begin
                        pend[src]  <= 1'b0;
                        cnf_r[src] <= 3'(ecf_pkg::ECF_CNF_NO_DEST);
                    end
                    else if (free_any && !busy[src])
                    begin
                        pend[src]        <= 1'b0;
                        busy[src]        <= 1'b1;
                        busy[free_idx]   <= 1'b1;
                        pair_r[src]      <= free_idx;
                        pair_r[free_idx] <= src;
                        cnf_r[src]       <= 3'(ecf_pkg::ECF_CNF_ARB_WON);
                    end
                    else if (all_blk)
                        cnf_r[src] <= 3'(ecf_pkg::ECF_CNF_BLK_PART);
                    else if (all_part)
                        cnf_r[src] <= 3'(ecf_pkg::ECF_CNF_WAIT_PART);
                    else if (all_conn)
                        cnf_r[src] <= 3'(ecf_pkg::ECF_CNF_WAIT_CONN);
                    else
                        cnf_r[src] <= 3'(ecf_pkg::ECF_CNF_NORMAL);
                end
                default:
                    state <= ecf_pkg::ECF_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnf           <= '0;
            pair_phy      <= '0;
            pair_valid    <= '0;
            port_mismatch <= '0;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                cnf[i*3 +: 3]       <= cnf_r[i];
                pair_phy[i*PW +: PW] <= pair_r[i];
            end
            pair_valid    <= busy;
            port_mismatch <= next_mismatch;
        end
    end

    // ------------------------------------------------------------
    // broadcast processor
    // ------------------------------------------------------------
    ecf_bcast_if bif ();
    assign bif.req      = bcast_req;
    assign bif.port_grp = port_grp;
    assign bif.cfg_done = cfg_done;

    ecf_broadcast_processor u_bcast
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bif   (bif)
    );

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bcast_tx     <= '0;
            bcast_change <= 1'b0;
        end
        else
        begin
            bcast_tx     <= bif.tx;
            bcast_change <= bif.tx_change;
        end
    end
endmodule
`default_nettype wire

//--- test/ecf_fabric_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ecf_fabric_asserts
(
    input  wire logic         mclk,          // device clock
    input  wire logic         reset_n,       // async reset, low
    input  wire logic [255:0] attached_addr, // per phy
    input  wire logic [7:0]   route_attr,    // per phy routing type
    input  wire logic [3:0]   path_req,      // path request pulse
    input  wire logic [3:0]   ppt_expired,   // partial timeout
    input  wire logic [3:0]   bcast_req,     // broadcast from phy
    input  wire logic         cfg_done,      // self-config done
    input  wire logic [11:0]  cnf,           // confirmation per phy
    input  wire logic [7:0]   pair_phy,      // paired phy per phy
    input  wire logic [3:0]   pair_valid,    // pairing active
    input  wire logic [3:0]   bcast_tx,      // transmit broadcast
    input  wire logic         bcast_change,  // transmit change
    input  wire logic [3:0]   port_mismatch  // attribute mismatch
);
    logic [3:0] mm_exp;
    logic [2:0] up;

    // --------------------------------------------------------------
    // expected attribute mismatch, settle counter after reset
    // --------------------------------------------------------------
    always_comb
    begin
        mm_exp = 4'h0;
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 4; j++)
                if (attached_addr[i*64+:64] == attached_addr[j*64+:64]
                    && route_attr[i*2+:2] != route_attr[j*2+:2])
                    mm_exp[i] = 1'b1;
    end

    always_ff @(posedge mclk or negedge reset_n)
        if (!reset_n)
            up <= 3'h0;
        else if (up != 3'h7)
            up <= up + 3'h1;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    req_ack_a: assert property (path_req[0] |-> ##[2:3] cnf[2:0] == 3'h1)
        else $error("path request not acknowledged");
    cnf_cause_a: assert property ((cnf[2:0] == 3'h0 ##1 cnf[2:0] != 3'h0)
        |-> $past(path_req[0], 2) || $past(path_req[0], 3))
        else $error("confirmation without request");
    won_pairs_a: assert property ((cnf[2:0] != 3'h5 ##1 cnf[2:0] == 3'h5)
        |-> ##[0:1] pair_valid[0])
        else $error("won without pairing");
    pair_both_a: assert property (pair_valid[0] |-> pair_valid[pair_phy[1:0]]
        && pair_phy[pair_phy[1:0]*2+:2] == 2'h0)
        else $error("pairing not symmetric");
    pair_self_a: assert property (pair_valid[0] |-> pair_phy[1:0] != 2'h0)
        else $error("phy paired with itself");
    bcast_cause_a: assert property (bcast_tx != 4'h0
        |-> $past(bcast_req, 2) != 4'h0 || $past(bcast_req, 3) != 4'h0)
        else $error("broadcast without request");
    change_tx_a: assert property ($rose(cfg_done) |-> ##[2:3] bcast_change)
        else $error("no change broadcast");
    attr_match_a: assert property (up == 3'h7 && mm_exp == $past(mm_exp)
        && mm_exp == $past(mm_exp, 2) |-> port_mismatch == mm_exp)
        else $error("port mismatch flag wrong");
    expire_lost_a: assert property (ppt_expired[0] && cnf[2:0] inside {[1:4]}
        |-> ##[1:4] cnf[2:0] == 3'h6)
        else $error("timeout not answered lost");

    cover property (cnf[2:0] == 3'h5);
    cover property (cnf[2:0] == 3'h3);
    cover property (bcast_tx == 4'h3);
    cover property (bcast_change);
endmodule
`default_nettype wire

//--- test/ecf_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecf_phy_model
(
    input  wire logic         mclk,        // device clock
    input  wire logic [11:0]  cnf,         // confirmations
    input  wire logic [3:0]   pair_valid,  // router pairing
    output logic      [3:0]   path_req,    // path request pulse
    output logic      [255:0] req_dest,    // destinations
    output logic      [7:0]   req_rate,    // requested rates
    output logic      [3:0]   ppt_expired, // timeout pulse
    output logic      [7:0]   phy_status   // pathway status
);
    ecf_pkg::ecf_stat_t stat_set [4];
    logic [2:0]         code;

    initial
    begin
        path_req    = 4'h0;
        req_dest    = '0;
        req_rate    = 8'h00;
        ppt_expired = 4'h0;
        for (int i = 0; i < 4; i++)
            stat_set[i] = ecf_pkg::ECF_STAT_AVAIL;
    end

    // --------------------------------------------------------------
    // one status per phy, own pending code reflected back
    // --------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            code = cnf[i*3+:3];
            if (pair_valid[i] || code == ecf_pkg::ECF_CNF_WAIT_CONN)
                phy_status[i*2+:2] = ecf_pkg::ECF_STAT_CONN;
            else if (code == ecf_pkg::ECF_CNF_BLK_PART)
                phy_status[i*2+:2] = ecf_pkg::ECF_STAT_BLOCKED;
            else if (code == ecf_pkg::ECF_CNF_WAIT_PART)
                phy_status[i*2+:2] = ecf_pkg::ECF_STAT_PARTIAL;
            else
                phy_status[i*2+:2] = stat_set[i];
        end
    end

    task automatic request(input int i, input logic [63:0] dest, input logic [1:0] rate);
        @(posedge mclk);
        path_req[i]        <= 1'b1;
        req_dest[i*64+:64] <= dest;
        req_rate[i*2+:2]   <= rate;
        @(posedge mclk);
        path_req[i] <= 1'b0;
    endtask

    task automatic expire(input int i);
        @(posedge mclk);
        ppt_expired[i] <= 1'b1;
        @(posedge mclk);
        ppt_expired[i] <= 1'b0;
    endtask

    // arguments no longer hold once the request has ended
    task automatic drop(input int i);
        @(posedge mclk);
        req_dest[i*64+:64] <= ~req_dest[i*64+:64];
    endtask
endmodule
`default_nettype wire

//--- test/test_expander_connection_fabric.sv
`timescale 1ns/1ps
`default_nettype none
module test_expander_connection_fabric;
    localparam logic [63:0] A0 = 64'h5000_0000_0000_0010;
    localparam logic [63:0] A1 = 64'h5000_0000_0000_0020;
    localparam logic [63:0] A2 = 64'h5000_0000_0000_0030;
    localparam logic [63:0] AT = 64'h5000_0000_0000_0040;
    localparam logic [63:0] AX = 64'h5000_0000_0000_0050;

    logic         mclk, reset_n, cfg_done, tbl_we, bcast_change;
    logic [255:0] attached_addr, req_dest;
    logic [7:0]   route_attr, req_rate, phy_status, pair_phy;
    logic [3:0]   path_req, ppt_expired, conn_close, bcast_req, pair_valid;
    logic [3:0]   bcast_tx, port_mismatch;
    logic [1:0]   tbl_idx, tbl_phy;
    logic [63:0]  tbl_addr;
    logic [11:0]  cnf;
    logic [2:0]   c;
    int           n_mismatch, checks;

    ecf_fabric i_ecf_fabric (.mclk(mclk), .reset_n(reset_n), .own_addr(AX),
        .attached_addr(attached_addr), .route_attr(route_attr), .phy_rate(8'hAA),
        .path_req(path_req), .req_dest(req_dest), .req_rate(req_rate),
        .ppt_expired(ppt_expired), .phy_status(phy_status), .conn_close(conn_close),
        .bcast_req(bcast_req), .cfg_done(cfg_done), .tbl_we(tbl_we), .tbl_idx(tbl_idx),
        .tbl_addr(tbl_addr), .tbl_phy(tbl_phy), .cnf(cnf), .pair_phy(pair_phy),
        .pair_valid(pair_valid), .bcast_tx(bcast_tx), .bcast_change(bcast_change),
        .port_mismatch(port_mismatch));
    ecf_phy_model i_ecf_phy_model (.mclk(mclk), .cnf(cnf), .pair_valid(pair_valid),
        .path_req(path_req), .req_dest(req_dest), .req_rate(req_rate),
        .ppt_expired(ppt_expired), .phy_status(phy_status));

    // --------------------------------------------------------------
    // compare and handshake helpers
    // --------------------------------------------------------------
    task automatic chk_cnf(input string what, input logic [2:0] exp, input logic [2:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wait_cnf(input int i, input logic [2:0] old, output logic [2:0] v);
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            v = cnf[i*3+:3];
            n++;
        end
        while (v === old && n < 30);
    endtask

    // request, then check the acceptance code and return the next one
    task automatic ask(input int i, input logic [63:0] d, input logic [1:0] r);
        i_ecf_phy_model.request(i, d, r);
        wait_cnf(i, cnf[i*3+:3], c);
        chk_cnf("accept", ecf_pkg::ECF_CNF_NORMAL, c);
        wait_cnf(i, c, c);
    endtask

    task automatic close(input int i);
        i_ecf_phy_model.drop(i);
        @(posedge mclk);
        conn_close[i] <= 1'b1;
        @(posedge mclk);
        conn_close[i] <= 1'b0;
        for (int n = 0; n < 8 && pair_valid !== 4'h0; n++)
            @(posedge mclk);
        #1;
        chk_bits("released", 8'h00, {4'h0, pair_valid});
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_won;
        ask(0, A2, 2'h1);
        chk_cnf("won", ecf_pkg::ECF_CNF_ARB_WON, c);
        chk_bits("pairs", 8'h05, {4'h0, pair_valid});
        chk_bits("pair 0", 8'h02, {6'h0, pair_phy[1:0]});
        chk_bits("pair 2", 8'h00, {6'h0, pair_phy[5:4]});
        close(0);
    endtask

    task automatic t_status;
        ecf_pkg::ecf_stat_t s2 [3] = '{ecf_pkg::ECF_STAT_PARTIAL, ecf_pkg::ECF_STAT_BLOCKED,
                                       ecf_pkg::ECF_STAT_CONN};
        logic [2:0] want [3] = '{3'h2, 3'h3, 3'h4};
        for (int k = 0; k < 3; k++)
        begin
            i_ecf_phy_model.stat_set[2] = s2[k];
            i_ecf_phy_model.stat_set[3] = ecf_pkg::ECF_STAT_BLOCKED;
            ask(0, A2, 2'h1);
            chk_cnf("pending", want[k], c);
            i_ecf_phy_model.expire(0);
            wait_cnf(0, c, c);
            chk_cnf("expired", ecf_pkg::ECF_CNF_ARB_LOST, c);
            i_ecf_phy_model.drop(0);
        end
        i_ecf_phy_model.stat_set[2] = ecf_pkg::ECF_STAT_CONN;
        i_ecf_phy_model.stat_set[3] = ecf_pkg::ECF_STAT_CONN;
        ask(0, A2, 2'h1);
        chk_cnf("busy", ecf_pkg::ECF_CNF_WAIT_CONN, c);
        i_ecf_phy_model.stat_set[2] = ecf_pkg::ECF_STAT_AVAIL;
        i_ecf_phy_model.stat_set[3] = ecf_pkg::ECF_STAT_AVAIL;
        wait_cnf(0, c, c);
        chk_cnf("retry won", ecf_pkg::ECF_CNF_ARB_WON, c);
        chk_bits("pair 0", 8'h02, {6'h0, pair_phy[1:0]});
        close(0);
    endtask

    task automatic t_refuse;
        ask(1, AX, 2'h1);
        chk_cnf("unknown", ecf_pkg::ECF_CNF_NO_DEST, c);
        i_ecf_phy_model.drop(1);
        ask(1, A0, 2'h3);
        chk_cnf("rate", ecf_pkg::ECF_CNF_NO_DEST, c);
        i_ecf_phy_model.drop(1);
        @(posedge mclk);
        tbl_we   <= 1'b1;
        tbl_addr <= AT;
        tbl_phy  <= 2'h0;
        @(posedge mclk);
        tbl_we <= 1'b0;
        ask(1, AT, 2'h1);
        chk_cnf("table", ecf_pkg::ECF_CNF_ARB_WON, c);
        chk_bits("pair 1", 8'h00, {6'h0, pair_phy[3:2]});
        close(1);
    endtask

    task automatic bcast(input int i, input logic [3:0] exp);
        @(posedge mclk);
        bcast_req[i] <= 1'b1;
        @(posedge mclk);
        bcast_req[i] <= 1'b0;
        #1;
        for (int n = 0; n < 6 && bcast_tx === 4'h0; n++)
            @(posedge mclk) #1;
        chk_bits("broadcast", {4'h0, exp}, {4'h0, bcast_tx});
    endtask

    task automatic t_misc;
        bcast(2, 4'h3);
        bcast(0, 4'hE);
        @(posedge mclk);
        cfg_done <= 1'b1;
        #1;
        for (int n = 0; n < 6 && bcast_change !== 1'b1; n++)
            @(posedge mclk) #1;
        chk_bits("change", 8'h01, {7'h0, bcast_change});
        @(posedge mclk);
        route_attr[7:6] <= 2'h2;
        #1;
        for (int n = 0; n < 6 && port_mismatch === 4'h0; n++)
            @(posedge mclk) #1;
        chk_bits("mismatch", 8'h0C, {4'h0, port_mismatch});
    endtask

    task automatic final_report;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial
    begin
        #100000;
        n_mismatch++;
        final_report();
    end

    initial
    begin
        {reset_n, cfg_done, tbl_we, tbl_idx, tbl_phy, tbl_addr} = '0;
        {conn_close, bcast_req, route_attr} = '0;
        attached_addr = {A2, A2, A1, A0};
        n_mismatch = 0;
        checks = 0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_won();
        t_status();
        t_refuse();
        t_misc();
        final_report();
    end
endmodule

bind ecf_fabric ecf_fabric_asserts i_ecf_fabric_asserts (.mclk, .reset_n, .attached_addr,
    .route_attr, .path_req, .ppt_expired, .bcast_req, .cfg_done, .cnf, .pair_phy,
    .pair_valid, .bcast_tx, .bcast_change, .port_mismatch);
`default_nettype wire
